// [core/timer_block_map.svh]
// Register offsets, field positions, reset values and codes of the timer pair.
`ifndef TIMER_BLOCK_MAP_SVH
`define TIMER_BLOCK_MAP_SVH

// Register byte offsets.
`define OFS_WIDTH_CONFIG   8'h00
`define OFS_CHAN_A_MODE    8'h04
`define OFS_CHAN_B_MODE    8'h08
`define OFS_TIMER_CONTROL  8'h0C
`define OFS_IRQ_MASK       8'h10
`define OFS_RAW_STATUS     8'h14
`define OFS_MASKED_STATUS  8'h18
`define OFS_STATUS_CLEAR   8'h1C
`define OFS_CHAN_A_LOAD    8'h28
`define OFS_CHAN_B_LOAD    8'h2C
`define OFS_CHAN_A_MATCH   8'h30
`define OFS_CHAN_A_PRESC   8'h38
`define OFS_CHAN_B_PRESC   8'h3C
`define OFS_CHAN_A_COUNT   8'h48
`define OFS_CHAN_B_COUNT   8'h4C
`define OFS_PIN_VIEW       8'h50

// Control register bit positions and writable bits.
`define CTL_A_EN           0
`define CTL_A_STALL        1
`define CTL_CLK_OVR        4
`define CTL_A_TRIG         5
`define CTL_B_EN           8
`define CTL_B_STALL        9
`define CTL_B_TRIG         13
`define CTL_WR_MASK        16'h2333

// Status, mask and clear bit positions and implemented bits.
`define ST_A_TO            0
`define ST_CLK_MATCH       3
`define ST_B_TO            8
`define ST_MASK            16'h0109

// Width configuration and mode field codes.
`define CFG_WIDE_TIMER     3'h0
`define CFG_WIDE_CLOCK     3'h1
`define CFG_SPLIT          3'h4
`define MODE_ONE_SHOT      2'h1
`define MODE_PERIODIC      2'h2

// Reset and load values.
`define RST_LOAD           16'hFFFF
`define RST_PRESCALE       8'h00
`define CLOCK_FIRST_LOAD   32'h0000_0001
`define CLOCK_ROLL_VALUE   32'h0000_0000

`endif

// [core/timer_block_pkg.sv]
// Types shared by the timer pair.
package timer_block_pkg;

    // Whole state of the timer pair, registered as one word.
    typedef struct packed {
        logic [2:0]  cfg;
        logic [1:0]  mode_a;
        logic [1:0]  mode_b;
        logic [15:0] ctl;
        logic [15:0] mask;
        logic [15:0] raw;
        logic [15:0] ila;
        logic [15:0] ilb;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [7:0]  pre_a;
        logic [7:0]  pre_b;
        logic [7:0]  pcnt_a;
        logic [7:0]  pcnt_b;
        logic [31:0] match;
        logic        clock_seen;
        logic        slow_prev;
        logic        trig_a;
        logic        trig_b;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_type;

endpackage : timer_block_pkg

// [core/timer_block.sv]
// Timer pair: two 16-bit down-counters, joinable to 32 bits, APB slave.
//
// Summary of operation
// - Reset: idle, controls default, both counters and load registers 0xFFFF.
// - Reset: both prescale values read 0x00.
// - Config 0 joins a 32-bit timer; config 1 joins a 32-bit clock.
// - Config 0x4 splits into two independent 16-bit channels.
// - Joined: channel A load write fills B with upper, A with lower half.
// - Joined: channel A count read returns B count high, A count low.
// - Joined timer is one down-counter; only channel A's mode field counts.
// - Joined timer counts down, reloads after zero, one-shot stops and disables.
// - Zero sets sticky timeout flag until cleared; masked copy when unmasked.
// - Enabled trigger pulses exactly one cycle when the counter reloads after zero.
// - Load write while running restarts the counter from it next cycle.
// - Stall bit freezes the joined timer until released.
// - Clock mode counts up; first selection loads 0x00000001.
// - Clock mode advances on the slow clock pin, not the system clock.
// - Count equal to match rolls to zero and keeps counting.
// - Match sets raw clock flag, masked copy and interrupt; one clear.
// - Stall override keeps the clock counting despite channel stalls.
// - Split channel is a 16-bit down-counter with 8-bit prescale.
// - Split channel reloads after zero; one-shot stops and disables.
// - Split channel zero sets sticky flag, masked copy and interrupt.
// - Odd capture pin serves split channels, even pin the joined modes.
// - Mode field 0x1 selects one-shot.
// - Mode field 0x2 selects periodic.
`timescale 1ns/1ps
`include "timer_block_map.svh"

module timer_block #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // APB slave.
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins.
    input  wire logic              slow_clock_pin,
    input  wire logic [1:0]        capture_compare_pin,
    // Events.
    output logic                   trig_a,
    output logic                   trig_b,
    output logic                   irq
);
    import timer_block_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Parameter check: the decoder needs an 8-bit offset field.
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end

    state_type cur_reg;
    state_type cur_next;

    logic [7:0] ofs;
    logic       in_range;
    logic       access;
    logic       wr_done;
    logic       wide;
    logic       clock_mode;

    // One prescaled step of a split channel: {zero, count, prescale count}.
    function automatic logic [24:0] step16(input logic [15:0] cnt,
                                           input logic [7:0]  pcnt,
                                           input logic [15:0] load,
                                           input logic [7:0]  pre);
        if (cnt == 16'h0000 && pcnt == 8'h00) begin
            step16 = {1'b1, load, pre};
        end else if (pcnt == 8'h00) begin
            step16 = {1'b0, cnt - 16'h0001, pre};
        end else begin
            step16 = {1'b0, cnt, pcnt - 8'h01};
        end
    endfunction : step16

    // A mode field only runs the counter when it holds a defined code.
    function automatic logic mode_runs(input logic [1:0] mode);
        mode_runs = (mode == `MODE_ONE_SHOT) || (mode == `MODE_PERIODIC);
    endfunction : mode_runs

    ////////////////////////////////////////////////////////////////////////
    // Bus decode shared by the next-state logic and the checks.
    assign ofs        = paddr[7:0];
    assign in_range   = ((paddr >> 8) == '0);
    assign access     = psel && penable;
    assign wr_done    = access && cur_reg.pready && pwrite && in_range;
    assign wide       = !cur_reg.cfg[2];
    assign clock_mode = wide && cur_reg.cfg[0];

    ////////////////////////////////////////////////////////////////////////
    // Next state: counting first, then bus writes, so software wins.
    always_comb begin
        logic [15:0] set_bits;
        logic [15:0] clr_bits;
        logic [24:0] st;
        logic [31:0] c32;
        logic [31:0] rd;
        logic        hit;
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        st       = 25'h0;
        c32      = {cur_reg.cnt_b, cur_reg.cnt_a};
        rd       = 32'h0000_0000;
        hit      = 1'b1;
        cur_next = cur_reg;
        cur_next.trig_a    = 1'b0;
        cur_next.trig_b    = 1'b0;
        cur_next.slow_prev = slow_clock_pin;

        if (!wide) begin
            // Split channels run independently with their own prescalers.
            if (cur_reg.ctl[`CTL_A_EN] && !cur_reg.ctl[`CTL_A_STALL] &&
                mode_runs(cur_reg.mode_a)) begin
                st = step16(cur_reg.cnt_a, cur_reg.pcnt_a, cur_reg.ila,
                            cur_reg.pre_a);
                cur_next.cnt_a  = st[23:8];
                cur_next.pcnt_a = st[7:0];
                if (st[24]) begin
                    set_bits[`ST_A_TO] = 1'b1;
                    cur_next.trig_a = cur_reg.ctl[`CTL_A_TRIG];
                    if (cur_reg.mode_a == `MODE_ONE_SHOT) begin
                        cur_next.ctl[`CTL_A_EN] = 1'b0;
                    end
                end
            end
            if (cur_reg.ctl[`CTL_B_EN] && !cur_reg.ctl[`CTL_B_STALL] &&
                mode_runs(cur_reg.mode_b)) begin
                st = step16(cur_reg.cnt_b, cur_reg.pcnt_b, cur_reg.ilb,
                            cur_reg.pre_b);
                cur_next.cnt_b  = st[23:8];
                cur_next.pcnt_b = st[7:0];
                if (st[24]) begin
                    set_bits[`ST_B_TO] = 1'b1;
                    cur_next.trig_b = cur_reg.ctl[`CTL_B_TRIG];
                    if (cur_reg.mode_b == `MODE_ONE_SHOT) begin
                        cur_next.ctl[`CTL_B_EN] = 1'b0;
                    end
                end
            end
        end else if (clock_mode) begin
            // The slow pin is sampled here, so counting is one rising edge
            // of it per step; stalls apply unless overridden.
            if (cur_reg.ctl[`CTL_A_EN] && slow_clock_pin &&
                !cur_reg.slow_prev && (cur_reg.ctl[`CTL_CLK_OVR] ||
                !(cur_reg.ctl[`CTL_A_STALL] ||
                  cur_reg.ctl[`CTL_B_STALL]))) begin
                if (c32 == cur_reg.match) begin
                    c32 = `CLOCK_ROLL_VALUE;
                    set_bits[`ST_CLK_MATCH] = 1'b1;
                end else begin
                    c32 = c32 + 32'h0000_0001;
                end
            end
        end else begin
            // Joined down-counter; channel B's mode is not looked at.
            if (cur_reg.ctl[`CTL_A_EN] && !cur_reg.ctl[`CTL_A_STALL] &&
                mode_runs(cur_reg.mode_a)) begin
                if (c32 == 32'h0000_0000) begin
                    c32 = {cur_reg.ilb, cur_reg.ila};
                    set_bits[`ST_A_TO] = 1'b1;
                    cur_next.trig_a = cur_reg.ctl[`CTL_A_TRIG];
                    if (cur_reg.mode_a == `MODE_ONE_SHOT) begin
                        cur_next.ctl[`CTL_A_EN] = 1'b0;
                    end
                end else begin
                    c32 = c32 - 32'h0000_0001;
                end
            end
        end
        if (wide) begin
            cur_next.cnt_b = c32[31:16];
            cur_next.cnt_a = c32[15:0];
        end

        // Register writes take effect at the edge that completes access.
        if (wr_done) begin
            unique case (ofs)
                `OFS_WIDTH_CONFIG: begin
                    cur_next.cfg = pwdata[2:0];
                    if (pwdata[2:0] == `CFG_WIDE_CLOCK &&
                        !cur_reg.clock_seen) begin
                        cur_next.cnt_b = 16'(`CLOCK_FIRST_LOAD >> 16);
                        cur_next.cnt_a = 16'(`CLOCK_FIRST_LOAD);
                        cur_next.clock_seen = 1'b1;
                    end
                end
                `OFS_CHAN_A_MODE:   cur_next.mode_a = pwdata[1:0];
                `OFS_CHAN_B_MODE:   cur_next.mode_b = pwdata[1:0];
                `OFS_TIMER_CONTROL: cur_next.ctl = pwdata[15:0] & `CTL_WR_MASK;
                `OFS_IRQ_MASK:      cur_next.mask = pwdata[15:0] & `ST_MASK;
                `OFS_STATUS_CLEAR:  clr_bits = pwdata[15:0] & `ST_MASK;
                `OFS_CHAN_A_LOAD: begin
                    cur_next.ila   = pwdata[15:0];
                    cur_next.cnt_a = pwdata[15:0];
                    if (wide) begin
                        cur_next.ilb   = pwdata[31:16];
                        cur_next.cnt_b = pwdata[31:16];
                    end
                end
                `OFS_CHAN_B_LOAD: begin
                    cur_next.ilb   = pwdata[15:0];
                    cur_next.cnt_b = pwdata[15:0];
                end
                `OFS_CHAN_A_MATCH:  cur_next.match = pwdata;
                `OFS_CHAN_A_PRESC:  cur_next.pre_a = pwdata[7:0];
                `OFS_CHAN_B_PRESC:  cur_next.pre_b = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // Hardware set wins over a clear in the same cycle.
        cur_next.raw = (cur_reg.raw & ~clr_bits) | set_bits;
        cur_next.irq = |(cur_next.raw & cur_next.mask);

        // Read mux; the wait state lets read data come from a flip-flop.
        unique case (ofs)
            `OFS_WIDTH_CONFIG:  rd = {29'h0, cur_reg.cfg};
            `OFS_CHAN_A_MODE:   rd = {30'h0, cur_reg.mode_a};
            `OFS_CHAN_B_MODE:   rd = {30'h0, cur_reg.mode_b};
            `OFS_TIMER_CONTROL: rd = {16'h0, cur_reg.ctl};
            `OFS_IRQ_MASK:      rd = {16'h0, cur_reg.mask};
            `OFS_RAW_STATUS:    rd = {16'h0, cur_reg.raw};
            `OFS_MASKED_STATUS: rd = {16'h0, cur_reg.raw & cur_reg.mask};
            `OFS_STATUS_CLEAR:  rd = 32'h0000_0000;
            `OFS_CHAN_A_LOAD:
                rd = wide ? {cur_reg.ilb, cur_reg.ila} : {16'h0, cur_reg.ila};
            `OFS_CHAN_B_LOAD:   rd = {16'h0, cur_reg.ilb};
            `OFS_CHAN_A_MATCH:  rd = cur_reg.match;
            `OFS_CHAN_A_PRESC:  rd = {24'h0, cur_reg.pre_a};
            `OFS_CHAN_B_PRESC:  rd = {24'h0, cur_reg.pre_b};
            `OFS_CHAN_A_COUNT:  rd = wide ? {cur_reg.cnt_b, cur_reg.cnt_a}
                                          : {16'h0, cur_reg.cnt_a};
            `OFS_CHAN_B_COUNT:  rd = {16'h0, cur_reg.cnt_b};
            `OFS_PIN_VIEW:      rd = {31'h0, wide ? capture_compare_pin[0]
                                               : capture_compare_pin[1]};
            default:            hit = 1'b0;
        endcase
        cur_next.pready = access && !cur_reg.pready;
        if (access && !cur_reg.pready) begin
            cur_next.prdata  = (hit && in_range && !pwrite) ? rd : 32'h0;
            cur_next.pslverr = !(hit && in_range);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_reg        <= '0;
            cur_reg.ila    <= `RST_LOAD;
            cur_reg.ilb    <= `RST_LOAD;
            cur_reg.cnt_a  <= `RST_LOAD;
            cur_reg.cnt_b  <= `RST_LOAD;
            cur_reg.pre_a  <= `RST_PRESCALE;
            cur_reg.pre_b  <= `RST_PRESCALE;
            cur_reg.pcnt_a <= `RST_PRESCALE;
            cur_reg.pcnt_b <= `RST_PRESCALE;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Outputs come straight from the state register.
    assign prdata  = cur_reg.prdata;
    assign pready  = cur_reg.pready;
    assign pslverr = cur_reg.pslverr;
    assign trig_a  = cur_reg.trig_a;
    assign trig_b  = cur_reg.trig_b;
    assign irq     = cur_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic wr_ila_split;
    logic wr_ctl;
    logic stall_hold;
    logic clock_hit;
    assign wr_ila_split = wr_done && ofs == `OFS_CHAN_A_LOAD && !wide;
    assign wr_ctl       = wr_done && ofs == `OFS_TIMER_CONTROL;
    assign stall_hold   = cur_reg.cfg == `CFG_WIDE_TIMER && !wr_done &&
                          cur_reg.ctl[`CTL_A_STALL];
    // A match step is any unstalled slow edge, with or without the override,
    // so the roll check also sees the plain running clock.
    assign clock_hit    = clock_mode && cur_reg.ctl[`CTL_A_EN] &&
                          (cur_reg.ctl[`CTL_CLK_OVR] ||
                           !(cur_reg.ctl[`CTL_A_STALL] ||
                             cur_reg.ctl[`CTL_B_STALL])) &&
                          slow_clock_pin &&
                          !cur_reg.slow_prev && !wr_done &&
                          {cur_reg.cnt_b, cur_reg.cnt_a} == cur_reg.match;

    chk_trig_one_cycle: assert property (trig_a |=> !trig_a)
        else $error("trigger A longer than one cycle");
    chk_trig_sets_flag: assert property (trig_a |-> cur_reg.raw[`ST_A_TO])
        else $error("trigger A without timeout flag");
    chk_irq_follows_mask: assert property
        (irq == |(cur_reg.raw & cur_reg.mask))
        else $error("interrupt does not match masked flags");
    chk_reset_values: assert property (@(posedge clk)
        $past(sys_rst) |-> cur_reg.cnt_a == `RST_LOAD &&
        cur_reg.ilb == `RST_LOAD && cur_reg.pre_a == `RST_PRESCALE)
        else $error("reset values wrong");
    chk_oneshot_stop: assert property (
        (!wide && cur_reg.mode_a == `MODE_ONE_SHOT && !wr_ctl &&
         cur_reg.ctl[`CTL_A_EN] && cur_reg.ctl[`CTL_A_TRIG] &&
         !cur_reg.ctl[`CTL_A_STALL] && cur_next.trig_a) |=>
        trig_a && !cur_reg.ctl[`CTL_A_EN])
        else $error("one-shot channel A kept running");
    chk_stall_holds: assert property (stall_hold |=>
        $stable({cur_reg.cnt_b, cur_reg.cnt_a}))
        else $error("stalled joined counter moved");
    chk_load_restart: assert property (wr_ila_split |=>
        cur_reg.cnt_a == $past(pwdata[15:0]))
        else $error("load write not taken by counter");
    chk_clock_roll: assert property (clock_hit |=>
        {cur_reg.cnt_b, cur_reg.cnt_a} == `CLOCK_ROLL_VALUE &&
        cur_reg.raw[`ST_CLK_MATCH])
        else $error("clock match did not roll over");
    chk_wide_read: assert property (
        (access && !pready && !pwrite && wide && in_range &&
         ofs == `OFS_CHAN_A_COUNT) |=>
        pready ##0 prdata == $past({cur_reg.cnt_b, cur_reg.cnt_a}))
        else $error("joined count read wrong");

    cov_wide_timeout: cover property (wide && !clock_mode && trig_a);
    cov_split_both:   cover property (trig_a && trig_b);
    cov_clock_match:  cover property (clock_hit);
    cov_bus_error:    cover property (pready && pslverr);
    cov_split_stop:   cover property (!wide && trig_a &&
                                      !cur_reg.ctl[`CTL_A_EN]);

endmodule : timer_block

// [test/testbench.sv]
// Self-checking bench for the timer pair, driven over its register bus.
`timescale 1ns/1ps
`include "timer_block_map.svh"

module testbench;

    ////////////////////////////////////////////////////////////////////////
    // One expected result of a bus transfer, queued by the driver.
    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
        logic        err;
        logic        rd;
    } note_type;

    logic        clk;
    logic        sys_rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        slow_clock_pin;
    logic [1:0]  capture_compare_pin;
    logic        trig_a;
    logic        trig_b;
    logic        irq;
    note_type    notes[$];
    note_type    cur;
    int          errors;
    int          n_checks;
    int          seed;
    int          cycles;
    logic [31:0] rnd;

    // Reset image: offset and value read back after reset.
    logic [7:0]  rst_ofs[9] = '{`OFS_WIDTH_CONFIG, `OFS_TIMER_CONTROL,
        `OFS_IRQ_MASK, `OFS_RAW_STATUS, `OFS_CHAN_A_PRESC, `OFS_CHAN_B_PRESC,
        `OFS_CHAN_B_LOAD, `OFS_CHAN_A_COUNT, `OFS_CHAN_B_COUNT};
    logic [31:0] rst_val[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF};

    timer_block #(.ADDR_W(8)) u_timer_block (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .paddr               (paddr),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .slow_clock_pin      (slow_clock_pin),
        .capture_compare_pin (capture_compare_pin),
        .trig_a              (trig_a),
        .trig_b              (trig_b),
        .irq                 (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Single-bit compare; case equality so an unknown never matches.
    task automatic cmp_bit(input logic got, input logic want);
        n_checks++;
        if (got !== want) begin
            errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : cmp_bit

    // Word compare against a window; lo equal to hi means an exact value.
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] lo,
                            input logic [31:0] hi);
        n_checks++;
        if ((lo === hi) ? (got !== lo)
            : ((^got) === 1'bx || got < lo || got > hi)) begin
            errors++;
            $display("BAD t=%0t got=%h want=%h..%h", $time, got, lo, hi);
        end
    endtask : cmp_word

    // One bus transfer; the request is held until pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [31:0] lo,
                       input logic [31:0] hi, input logic err);
        int n;
        notes.push_back('{lo, hi, err, !w});
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("BAD t=%0t got=%h want=%h", $time, pready, 1'b1);
            stop_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(a, 1'b0, 32'h0, v, v, 1'b0);
    endtask : rd

    // Waits a bounded time for a trigger pulse, then checks that it fell.
    task automatic wait_trig(input logic b, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((b ? trig_b : trig_a) !== 1'b1 && n < lim);
        if ((b ? trig_b : trig_a) !== 1'b1) begin
            errors++;
            $display("BAD t=%0t got=%h want=%h", $time, 1'b0, 1'b1);
            stop_test();
        end
        @(posedge clk);
        cmp_bit(b ? trig_b : trig_a, 1'b0);
    endtask : wait_trig

    // One slow pin period, long enough for the edge detector to see one rising edge.
    task automatic slow_pulse();
        slow_clock_pin <= 1'b1;
        repeat (4) @(posedge clk);
        slow_clock_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : slow_pulse

    ////////////////////////////////////////////////////////////////////////
    // Monitor: each completed transfer takes the oldest note and compares.
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                errors++;
                $display("BAD t=%0t got=%h want=%h", $time, pready, 1'b0);
            end else begin
                cur = notes.pop_front();
                cmp_bit(pslverr, cur.err);
                if (cur.rd) begin
                    cmp_word(prdata, cur.lo, cur.hi);
                end
            end
        end
    end

    // Main sequence: reset, joined timer, clock mode, then split channels.
    initial begin
        seed = 32'h5865;
        sys_rst = 1'b1;
        {paddr, psel, penable, pwrite, pwdata} = '0;
        slow_clock_pin = 1'b0;
        capture_compare_pin = 2'b01;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) rd(rst_ofs[i], rst_val[i]);
        apb(8'h44, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(8'h40, 1'b1, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
        rd(`OFS_PIN_VIEW, 32'h1);
        // Joined one-shot; channel B's mode must be ignored.
        wr(`OFS_CHAN_A_MODE, `MODE_ONE_SHOT);
        wr(`OFS_CHAN_B_MODE, `MODE_PERIODIC);
        wr(`OFS_CHAN_A_LOAD, 32'h0003_0010);
        rd(`OFS_CHAN_B_LOAD, 32'h3);
        rd(`OFS_CHAN_A_COUNT, 32'h0003_0010);
        wr(`OFS_CHAN_A_LOAD, 32'h10);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_TIMER_CONTROL, 32'h21);
        wait_trig(1'b0, 40, cycles);
        cmp_word(32'(cycles), 32'd15, 32'd18);
        cmp_bit(irq, 1'b1);
        rd(`OFS_RAW_STATUS, 32'h1);
        rd(`OFS_MASKED_STATUS, 32'h1);
        rd(`OFS_TIMER_CONTROL, 32'h20);
        rd(`OFS_CHAN_A_COUNT, 32'h10);
        wr(`OFS_STATUS_CLEAR, 32'h1);
        rd(`OFS_RAW_STATUS, 32'h0);
        cmp_bit(irq, 1'b0);
        // Joined periodic, masked, first held by the stall bit.
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_CHAN_A_MODE, `MODE_PERIODIC);
        wr(`OFS_CHAN_A_LOAD, 32'h8);
        wr(`OFS_TIMER_CONTROL, 32'h23);
        repeat (20) @(posedge clk);
        rd(`OFS_CHAN_A_COUNT, 32'h8);
        wr(`OFS_TIMER_CONTROL, 32'h21);
        wait_trig(1'b0, 20, cycles);
        wait_trig(1'b0, 20, cycles);
        cmp_word(32'(cycles), 32'd6, 32'd9);
        rd(`OFS_MASKED_STATUS, 32'h0);
        cmp_bit(irq, 1'b0);
        wr(`OFS_CHAN_A_LOAD, 32'h300);
        apb(`OFS_CHAN_A_COUNT, 1'b0, 32'h0, 32'h2F0, 32'h300, 1'b0);
        rd(`OFS_TIMER_CONTROL, 32'h21);
        wr(`OFS_TIMER_CONTROL, 32'h0);
        wr(`OFS_STATUS_CLEAR, 32'h1);
        // Clock mode: counts slow pin edges only, rolls at the match.
        wr(`OFS_WIDTH_CONFIG, `CFG_WIDE_CLOCK);
        rd(`OFS_CHAN_A_COUNT, `CLOCK_FIRST_LOAD);
        wr(`OFS_CHAN_A_MATCH, 32'h3);
        wr(`OFS_IRQ_MASK, 32'h8);
        wr(`OFS_TIMER_CONTROL, 32'h13);
        repeat (30) @(posedge clk);
        rd(`OFS_CHAN_A_COUNT, 32'h1);
        slow_pulse();
        rd(`OFS_CHAN_A_COUNT, 32'h2);
        wr(`OFS_TIMER_CONTROL, 32'h3);
        slow_pulse();
        rd(`OFS_CHAN_A_COUNT, 32'h2);
        wr(`OFS_TIMER_CONTROL, 32'h1);
        slow_pulse();
        slow_pulse();
        apb(`OFS_CHAN_A_COUNT, 1'b0, 32'h0, 32'h0, 32'h1, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h8);
        rd(`OFS_MASKED_STATUS, 32'h8);
        cmp_bit(irq, 1'b1);
        wr(`OFS_STATUS_CLEAR, 32'h8);
        rd(`OFS_MASKED_STATUS, 32'h0);
        cmp_bit(irq, 1'b0);
        slow_pulse();
        apb(`OFS_CHAN_A_COUNT, 1'b0, 32'h0, 32'h1, 32'h2, 1'b0);
        // Split channels: 16-bit views, random loads, A and B one-shot.
        wr(`OFS_TIMER_CONTROL, 32'h0);
        wr(`OFS_WIDTH_CONFIG, `CFG_SPLIT);
        rd(`OFS_PIN_VIEW, 32'h0);
        capture_compare_pin <= 2'b10;
        rd(`OFS_PIN_VIEW, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wr(`OFS_CHAN_A_LOAD, rnd);
            rd(`OFS_CHAN_A_LOAD, {16'h0, rnd[15:0]});
            rd(`OFS_CHAN_A_COUNT, {16'h0, rnd[15:0]});
        end
        wr(`OFS_CHAN_A_MODE, `MODE_ONE_SHOT);
        wr(`OFS_CHAN_A_LOAD, 32'h5);
        wr(`OFS_CHAN_B_MODE, `MODE_ONE_SHOT);
        wr(`OFS_CHAN_B_PRESC, 32'h2);
        wr(`OFS_CHAN_B_LOAD, 32'h3);
        wr(`OFS_IRQ_MASK, 32'h100);
        wr(`OFS_TIMER_CONTROL, 32'h2121);
        wait_trig(1'b1, 40, cycles);
        cmp_word(32'(cycles), 32'd8, 32'd13);
        cmp_bit(irq, 1'b1);
        rd(`OFS_RAW_STATUS, 32'h101);
        rd(`OFS_TIMER_CONTROL, 32'h2020);
        rd(`OFS_CHAN_A_COUNT, 32'h5);
        rd(`OFS_CHAN_B_COUNT, 32'h3);
        wr(`OFS_STATUS_CLEAR, 32'h101);
        rd(`OFS_RAW_STATUS, 32'h0);
        cmp_bit(irq, 1'b0);
        stop_test();
    end

endmodule : testbench
